//--- ui_pkg.sv
// Shared constants and carrier types for the memory user-interface front end
`default_nettype none
package ui_pkg;
   // Operation field encodings, upper nibble of the command word
   localparam logic [3:0] OP_REFRESH = 4'h1;
   localparam logic [3:0] OP_PRECH_ALL = 4'h2;
   localparam logic [3:0] OP_WRITE = 4'h4;
   localparam logic [3:0] OP_READ = 4'h5;
   // Burst length indication codes
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h4;
   // Field widths of the command word
   localparam int ADDR_W = 32;
   localparam int OP_W = 4;
   localparam int CMD_W = ADDR_W + OP_W;
   // Command FIFO shape and nearly-full margin
   localparam int CMD_FIFO_DEPTH = 16;
   localparam int CMD_AF_MARGIN = 8;
   // Write-data FIFO slice shape and nearly-full margin
   localparam int WDF_DEPTH = 512;
   localparam int WDF_SLICE_W = 36;
   localparam int WDF_AF_MARGIN = 14;
   localparam int LANE_W = 8;
   // Cycles between command decode and first data pop, and last beat index of the data phase
   localparam int CMD_GAP_CYCLES = 2;
   localparam logic [1:0] DATA_BEATS_BL8 = 2'h3;
   localparam logic [1:0] DATA_BEATS_BL4 = 2'h1;
   // Reset values
   localparam logic RST_FLAG = 1'b0;
   localparam logic RST_UI_RESET = 1'b1;

   // Command word: operation in bits 35:32, memory location in bits 31:0
   typedef struct packed {
      logic [OP_W-1:0] op;
      logic [ADDR_W-1:0] addr;
   } cmd_word_s;
endpackage
`default_nettype wire

//--- ui_fifo.sv
// Show-ahead flip-flop FIFO with registered nearly-full flag
`default_nettype none
module ui_fifo #(
   parameter int W = 36,
   parameter int DEPTH = 16,
   parameter int AF_MARGIN = 8
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_push,
   input wire logic [W-1:0] i_din,
   input wire logic i_pop,
   output logic [W-1:0] o_head,
   output logic o_empty,
   output logic o_nearly_full
);
   import ui_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] AF_LEVEL = (AW+1)'(DEPTH - AF_MARGIN);
   localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

   logic [W-1:0] mem_r [DEPTH];     // Storage
   logic [AW-1:0] wp_r;             // Write index
   logic [AW-1:0] rp_r;             // Read index
   logic [AW:0] cnt_r;              // Occupancy
   logic [AW:0] cnt_nxt;
   wire do_push = i_push && (cnt_r != FULL_LEVEL);   // Push into a full FIFO is dropped
   wire do_pop = i_pop && (cnt_r != '0);             // Pop of an empty FIFO is dropped

   assign o_head = mem_r[rp_r];
   assign o_empty = (cnt_r == '0);
   assign cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);

   // Pointers, occupancy and flag
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         o_nearly_full <= RST_FLAG;
      end
      else
      begin
         if (do_push)
            wp_r <= wp_r + 1'b1;
         if (do_pop)
            rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_nxt;
         o_nearly_full <= (cnt_nxt >= AF_LEVEL);
      end
   end

   // Data storage, no reset needed
   always_ff @(posedge i_mclk)
   begin
      if (do_push)
         mem_r[wp_r] <= i_din;
   end
endmodule
`default_nettype wire

//--- ddr2_fifo_user_interface.sv
// User-side command, write-data and read-return front end of the memory controller
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`default_nettype none
module ddr2_fifo_user_interface #(
   parameter int DQ_WIDTH = 8,
   parameter int BURST_LEN = 8,
   parameter bit MASK_EN = 1'b1
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_cmd_fifo_push,
   input wire ui_pkg::cmd_word_s i_user_cmd_word,
   output logic o_cmd_fifo_nearly_full,
   input wire logic i_wdf_push,
   input wire logic [4*DQ_WIDTH-1:0] i_wdf_data,
   input wire logic [DQ_WIDTH/2-1:0] i_wdf_mask,
   output logic o_wdf_nearly_full,
   input wire logic i_init_done,
   input wire logic i_calib_done,
   output logic o_init_complete,
   input wire logic i_ctrl_ready,
   output logic o_mem_cmd_valid,
   output ui_pkg::cmd_word_s o_mem_cmd,
   output logic o_mem_wr_valid,
   output logic [4*DQ_WIDTH-1:0] o_mem_wr_data,
   output logic [DQ_WIDTH/2-1:0] o_mem_wr_mask,
   input wire logic i_core_rd_valid,
   input wire logic [4*DQ_WIDTH-1:0] i_core_rd_data,
   output logic [DQ_WIDTH-1:0] o_rd_beat_rise_first,
   output logic [DQ_WIDTH-1:0] o_rd_beat_rise_second,
   output logic [DQ_WIDTH-1:0] o_rd_beat_fall_first,
   output logic [DQ_WIDTH-1:0] o_rd_beat_fall_second,
   output logic o_rd_valid,
   output logic [2:0] o_burst_len_code,
   output logic o_ui_reset
);
   import ui_pkg::*;
   localparam int N = DQ_WIDTH;          // Memory data width
   localparam int NS = DQ_WIDTH / LANE_W; // Byte lanes, one slice each
   localparam int UW = 4 * N;            // User write word width
   localparam int MW = UW / LANE_W;      // Mask width
   localparam logic [1:0] LAST_BEAT = (BURST_LEN == 8) ? DATA_BEATS_BL8 : DATA_BEATS_BL4;

   typedef enum {ST_IDLE, ST_DECODE, ST_GAP, ST_DATA} seq_e;

   // Operation decode shared by the sequencer and checks
   function automatic logic op_known(input logic [OP_W-1:0] op);
      op_known = (op == OP_REFRESH) || (op == OP_PRECH_ALL) ||
                 (op == OP_WRITE) || (op == OP_READ);
   endfunction

   seq_e state_r;                  // Sequencer state
   seq_e state_nxt;
   cmd_word_s cmd_r;               // Popped command under decode
   logic [1:0] beat_r;             // Data phase beat index
   logic [1:0] gap_r;              // Gap counter after decode
   cmd_word_s cmd_head;            // Command FIFO head
   logic cmd_empty;
   logic [UW-1:0] wdf_head_data;   // Reassembled write word at slice heads
   logic [MW-1:0] wdf_head_mask;
   logic [MW-1:0] mask_in;         // Mask after the enable option
   logic [NS-1:0] slice_empty;
   logic [NS-1:0] slice_af;

   // Command FIFO pop when idle, calibrated and controller can take work
   wire cmd_fifo_pop = (state_r == ST_IDLE) && !cmd_empty && o_init_complete && i_ctrl_ready;
   // Write data pops on even beats of the data phase, stalling if data is late
   wire wdf_beat = (state_r == ST_DATA) && !beat_r[0];
   wire wdf_pop = wdf_beat && !slice_empty[0];
   wire data_stall = wdf_beat && slice_empty[0];
   wire is_write = (cmd_r.op == OP_WRITE);
   wire issue_cmd = (state_r == ST_DECODE) && op_known(cmd_r.op);

   // One shared queue holds reads, writes and maintenance commands
   ui_fifo #(.W(CMD_W), .DEPTH(CMD_FIFO_DEPTH), .AF_MARGIN(CMD_AF_MARGIN)) u_cmd_fifo (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_push(i_cmd_fifo_push),
      .i_din(i_user_cmd_word),
      .i_pop(cmd_fifo_pop),
      .o_head(cmd_head),
      .o_empty(cmd_empty),
      .o_nearly_full(o_cmd_fifo_nearly_full)
   );

   // Mask path is forced off when masking is not configured
   assign mask_in = MASK_EN ? i_wdf_mask : '0;

   // One 36-bit slice per byte lane: rise bytes and masks, then fall bytes and masks
   genvar g;
   generate
      for (g = 0; g < NS; g++)
      begin : g_slice
         logic [WDF_SLICE_W-1:0] slice_in;
         logic [WDF_SLICE_W-1:0] slice_out;
         assign slice_in = {mask_in[3*NS+g], mask_in[2*NS+g],
                            i_wdf_data[3*N+g*LANE_W +: LANE_W],
                            i_wdf_data[2*N+g*LANE_W +: LANE_W],
                            mask_in[NS+g], mask_in[g],
                            i_wdf_data[N+g*LANE_W +: LANE_W],
                            i_wdf_data[g*LANE_W +: LANE_W]};
         ui_fifo #(.W(WDF_SLICE_W), .DEPTH(WDF_DEPTH), .AF_MARGIN(WDF_AF_MARGIN)) u_wdf (
            .i_mclk(i_mclk),
            .i_sys_rst(i_sys_rst),
            .i_push(i_wdf_push),
            .i_din(slice_in),
            .i_pop(wdf_pop),
            .o_head(slice_out),
            .o_empty(slice_empty[g]),
            .o_nearly_full(slice_af[g])
         );
         assign wdf_head_data[g*LANE_W +: LANE_W] = slice_out[7:0];
         assign wdf_head_data[N+g*LANE_W +: LANE_W] = slice_out[15:8];
         assign wdf_head_mask[g] = slice_out[16];
         assign wdf_head_mask[NS+g] = slice_out[17];
         assign wdf_head_data[2*N+g*LANE_W +: LANE_W] = slice_out[25:18];
         assign wdf_head_data[3*N+g*LANE_W +: LANE_W] = slice_out[33:26];
         assign wdf_head_mask[2*NS+g] = slice_out[34];
         assign wdf_head_mask[3*NS+g] = slice_out[35];
      end
   endgenerate

   // All slices move together, so lane zero speaks for the whole data queue
   assign o_wdf_nearly_full = slice_af[0];

   // Sequencer next state: pop, decode, gap, data phase
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (cmd_fifo_pop)
               state_nxt = ST_DECODE;
         ST_DECODE:
            // Writes wait out the gap; other known or unknown codes are done
            state_nxt = is_write ? ST_GAP : ST_IDLE;
         ST_GAP:
            if (gap_r == 2'(CMD_GAP_CYCLES - 2))
               state_nxt = ST_DATA;
         ST_DATA:
            if (!data_stall && (beat_r == LAST_BEAT))
               state_nxt = ST_IDLE;
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state_r <= ST_IDLE;
         cmd_r <= '0;
         beat_r <= '0;
         gap_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         if (cmd_fifo_pop)
            cmd_r <= cmd_head;
         gap_r <= (state_r == ST_GAP) ? gap_r + 2'h1 : 2'h0;
         if (state_r != ST_DATA)
            beat_r <= '0;
         else if (!data_stall)
            beat_r <= beat_r + 2'h1;
      end
   end

   // Command and write data toward the controller core
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_mem_cmd_valid <= RST_FLAG;
         o_mem_cmd <= '0;
         o_mem_wr_valid <= RST_FLAG;
         o_mem_wr_data <= '0;
         o_mem_wr_mask <= '0;
      end
      else
      begin
         o_mem_cmd_valid <= issue_cmd;
         if (issue_cmd)
            o_mem_cmd <= cmd_r;
         o_mem_wr_valid <= wdf_pop;
         if (wdf_pop)
         begin
            o_mem_wr_data <= wdf_head_data;
            o_mem_wr_mask <= wdf_head_mask;
         end
      end
   end

   // Read return, status and reset toward the user
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_rd_beat_rise_first <= '0;
         o_rd_beat_rise_second <= '0;
         o_rd_beat_fall_first <= '0;
         o_rd_beat_fall_second <= '0;
         o_rd_valid <= RST_FLAG;
         o_init_complete <= RST_FLAG;
         o_burst_len_code <= BL_CODE_4;
         o_ui_reset <= RST_UI_RESET;
      end
      else
      begin
         if (i_core_rd_valid)
         begin
            o_rd_beat_rise_first <= i_core_rd_data[0 +: N];
            o_rd_beat_rise_second <= i_core_rd_data[N +: N];
            o_rd_beat_fall_first <= i_core_rd_data[2*N +: N];
            o_rd_beat_fall_second <= i_core_rd_data[3*N +: N];
         end
         o_rd_valid <= i_core_rd_valid;
         o_init_complete <= i_init_done && i_calib_done;
         o_burst_len_code <= (BURST_LEN == 8) ? BL_CODE_8 : BL_CODE_4;
         o_ui_reset <= 1'b0;
      end
   end

   // Checks; cycle count since a command pop for sequencing bounds
   logic [3:0] since_pop_r;
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         since_pop_r <= '0;
      else if (cmd_fifo_pop)
         since_pop_r <= 4'h1;
      else if (since_pop_r != 4'h0 && since_pop_r != 4'hf)
         since_pop_r <= since_pop_r + 4'h1;
   end

   sequence s_write_popped;
      cmd_fifo_pop ##1 (cmd_r.op == OP_WRITE);
   endsequence
   sequence s_first_data;
      ##(CMD_GAP_CYCLES) (wdf_beat && beat_r == 2'h0);
   endsequence

   property p_write_gap;
      @(posedge i_mclk) disable iff (i_sys_rst)
      s_write_popped |-> s_first_data;
   endproperty
   a_write_gap: assert property (p_write_gap) else $error("data pop gap wrong");

   property p_no_early_data;
      @(posedge i_mclk) disable iff (i_sys_rst)
      wdf_pop |-> (since_pop_r >= 4'h3);
   endproperty
   a_no_early_data: assert property (p_no_early_data) else $error("data popped early");

   property p_bl8_last;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (BURST_LEN == 8) ##0 s_write_popped ##2 !data_stall ##2 !data_stall
         |-> ##2 (state_r == ST_IDLE);
   endproperty
   a_bl8_last: assert property (p_bl8_last) else $error("burst eight phase length wrong");

   property p_cmd_issue;
      @(posedge i_mclk) disable iff (i_sys_rst)
      cmd_fifo_pop ##1 op_known(cmd_r.op) |-> ##1 (o_mem_cmd_valid && o_mem_cmd == $past(cmd_r));
   endproperty
   a_cmd_issue: assert property (p_cmd_issue) else $error("known command not issued");

   property p_unknown_drop;
      @(posedge i_mclk) disable iff (i_sys_rst)
      o_mem_cmd_valid |-> op_known(o_mem_cmd.op);
   endproperty
   a_unknown_drop: assert property (p_unknown_drop) else $error("unknown command issued");

   property p_rd_beats;
      @(posedge i_mclk) disable iff (i_sys_rst)
      i_core_rd_valid |=> o_rd_valid && o_rd_beat_rise_first == $past(i_core_rd_data[0 +: N])
         && o_rd_beat_fall_second == $past(i_core_rd_data[3*N +: N]);
   endproperty
   a_rd_beats: assert property (p_rd_beats) else $error("read beat order wrong");

   property p_rd_valid;
      @(posedge i_mclk) disable iff (i_sys_rst)
      o_rd_valid |-> $past(i_core_rd_valid);
   endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read valid without data");

   property p_init;
      @(posedge i_mclk) disable iff (i_sys_rst)
      o_init_complete |-> $past(i_init_done && i_calib_done);
   endproperty
   a_init: assert property (p_init) else $error("init complete without both done");

   property p_bl_code;
      @(posedge i_mclk) disable iff (i_sys_rst)
      !o_ui_reset |-> o_burst_len_code == ((BURST_LEN == 8) ? BL_CODE_8 : BL_CODE_4);
   endproperty
   a_bl_code: assert property (p_bl_code) else $error("burst code wrong");

   property p_flags_after_reset;
      @(posedge i_mclk) disable iff (i_sys_rst)
      $fell(o_ui_reset) |-> !o_cmd_fifo_nearly_full && !o_wdf_nearly_full;
   endproperty
   a_flags_after_reset: assert property (p_flags_after_reset) else $error("full flag set at start");
endmodule
`default_nettype wire

//--- ui_user_model.sv
// Behavioural user backend that pushes commands and write words
`default_nettype none
module ui_user_model (
   input wire logic i_mclk,
   input wire logic i_full,
   output logic o_cmd_push,
   output ui_pkg::cmd_word_s o_cmd,
   output logic o_wdf_push,
   output logic [31:0] o_data,
   output logic [3:0] o_mask
);
   timeunit 1ns;
   timeprecision 1ps;
   import ui_pkg::*;

   // Idle strobes at power-up
   initial
   begin
      o_cmd_push = 1'b0;
      o_cmd = '0;
      o_wdf_push = 1'b0;
      o_data = '0;
      o_mask = '0;
   end

   // One command push, started only while both full flags are low; word is garbled once released
   task automatic push_cmd(input logic [3:0] op, input logic [31:0] a);
      @(posedge i_mclk);
      while (i_full)
         @(posedge i_mclk);
      o_cmd_push <= 1'b1;
      o_cmd <= {op, a};
      @(posedge i_mclk);
      o_cmd_push <= 1'b0;
      o_cmd <= ~o_cmd;
   endtask

   // One write word of four beats with its mask; never delayed, the command is already queued
   task automatic push_data(input logic [31:0] d, input logic [3:0] m);
      @(posedge i_mclk);
      o_wdf_push <= 1'b1;
      o_data <= d;
      o_mask <= m;
      @(posedge i_mclk);
      o_wdf_push <= 1'b0;
      o_data <= ~o_data;
      o_mask <= ~o_mask;
   endtask
endmodule
`default_nettype wire

//--- test_ddr2_fifo_user_interface.sv
// Self-checking bench for the memory user-interface front end
`default_nettype none
module test_ddr2_fifo_user_interface;
   timeunit 1ns;
   timeprecision 1ps;
   import ui_pkg::*;
   // Design side signals
   logic mclk, rst, c_push, w_push, ini, cal, rdy, rv;
   logic cnf, wnf, initc, mcv, mwv, rdv, uir;
   cmd_word_s cw, mc;
   logic [31:0] wd, mwd, crd, pd;
   logic [3:0] wm, mwm;
   logic [7:0] b0, b1, b2, b3;
   logic [2:0] blc;
   // Bench model state
   cmd_word_s eq[$];
   logic [35:0] dq[$];
   logic pv;
   int seed, err_count, cmp_count, cyc, wcyc, nw;
   localparam logic [3:0] OPS[8] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h7, 4'h0, 4'h5, 4'h4};
   localparam int BL = 8; // Burst length under test, 4 or 8

   ddr2_fifo_user_interface #(.DQ_WIDTH(8), .BURST_LEN(BL), .MASK_EN(1'b1)) u_dut (
      .i_mclk(mclk), .i_sys_rst(rst), .i_cmd_fifo_push(c_push), .i_user_cmd_word(cw),
      .o_cmd_fifo_nearly_full(cnf), .i_wdf_push(w_push), .i_wdf_data(wd), .i_wdf_mask(wm),
      .o_wdf_nearly_full(wnf), .i_init_done(ini), .i_calib_done(cal),
      .o_init_complete(initc), .i_ctrl_ready(rdy), .o_mem_cmd_valid(mcv), .o_mem_cmd(mc),
      .o_mem_wr_valid(mwv), .o_mem_wr_data(mwd), .o_mem_wr_mask(mwm),
      .i_core_rd_valid(rv), .i_core_rd_data(crd), .o_rd_beat_rise_first(b0),
      .o_rd_beat_rise_second(b1), .o_rd_beat_fall_first(b2), .o_rd_beat_fall_second(b3),
      .o_rd_valid(rdv), .o_burst_len_code(blc), .o_ui_reset(uir));

   ui_user_model u_usr (
      .i_mclk(mclk), .i_full(cnf | wnf), .o_cmd_push(c_push), .o_cmd(cw),
      .o_wdf_push(w_push), .o_data(wd), .o_mask(wm));

   // Free-running clock, 8 ns period
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Verdict and end of run
   task end_sim;
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Compare one value with its expectation
   task chk(input logic [35:0] got, input logic [35:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // Push a command; known codes join the expected queue
   task cmd(input logic [3:0] op);
      logic [31:0] a;
      a = $random(seed);
      if (op inside {OP_REFRESH, OP_PRECH_ALL, OP_WRITE, OP_READ})
         eq.push_back({op, a});
      u_usr.push_cmd(op, a);
   endtask

   // Push a random write word and record it
   task dat;
      logic [31:0] d;
      logic [3:0] m;
      d = $random(seed);
      m = $random(seed);
      dq.push_back({m, d});
      u_usr.push_data(d, m);
   endtask

   // Wait, bounded, until the model queues drain
   task drain;
      for (int k = 0; k < 100 && eq.size() + dq.size() > 0; k++)
         @(posedge mclk);
      chk(36'(eq.size() + dq.size()), 36'h0_0000_0000);
   endtask

   // Cycle count and hang guard
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         end_sim;
      end
   end

   // Output monitor, sampled at the settled falling edge
   always @(negedge mclk)
   begin
      if (mcv)
      begin
         chk(mc, eq.pop_front());
         if (mc.op == OP_WRITE)
         begin
            wcyc = cyc;
            nw = 0;
         end
      end
      if (mwv)
      begin
         nw++;
         chk({mwm, mwd}, dq.pop_front());
         chk(36'(cyc - wcyc), 36'(2 * nw));
      end
      chk(36'(rdv), 36'(pv));
      if (pv)
         chk(36'({b3, b2, b1, b0}), 36'(pd));
      pv = rv;
      pd = crd;
   end

   // Main sequence
   initial
   begin
      seed = 29450;
      rst = 1'b1;
      ini = 1'b0;
      cal = 1'b0;
      rdy = 1'b0;
      rv = 1'b0;
      crd = '0;
      pv = 1'b0;
      pd = '0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      chk(36'({cnf, wnf}), 36'h0_0000_0000);
      chk(36'(blc), 36'((BL == 8) ? BL_CODE_8 : BL_CODE_4));
      chk(36'(uir), 36'h0_0000_0000);
      // Init done alone must not complete init
      @(posedge mclk) ini <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk(36'(initc), 36'h0_0000_0000);
      @(posedge mclk) cal <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk(36'(initc), 36'h0_0000_0001);
      // Push commands up to the nearly-full level of the command queue with the core stalled
      foreach (OPS[i])
      begin
         cmd(OPS[i]);
         #1 chk(36'(cnf), 36'(i == 7));
         if (OPS[i] == OP_WRITE)
         begin
            repeat (BL / 4) dat;
         end
      end
      @(posedge mclk) rdy <= 1'b1;
      drain;
      #1 chk(36'(cnf), 36'h0_0000_0000);
      // Data pushed two cycles after its command
      cmd(OP_WRITE);
      repeat (BL / 4) dat;
      cmd(OP_READ);
      drain;
      // Random read returns from the core
      repeat (8)
      begin
         @(posedge mclk);
         rv <= 1'($random(seed));
         crd <= $random(seed);
      end
      @(posedge mclk) rv <= 1'b0;
      repeat (3) @(posedge mclk);
      end_sim;
   end
endmodule
`default_nettype wire
